/* logic/acr_pkg.sv */
// constants and types shared by the channel, range and dac-clear register block
`default_nettype none
package acr_pkg;
	localparam int          REG_W             = 16;
	localparam int          NUM_IN            = 16;
	localparam int          NUM_DAC           = 12;
	localparam int          NUM_ALARM         = 13;
	// register word indices; byte address is four times the index
	localparam logic [7:0]  IDX_CH_LOWER      = 8'h50;
	localparam logic [7:0]  IDX_CH_UPPER      = 8'h51;
	localparam logic [7:0]  IDX_RANGE         = 8'h52;
	localparam logic [7:0]  IDX_CLR_SOURCE    = 8'h53;
	localparam logic [7:0]  IDX_CLR_EN        = 8'h54;
	localparam logic [7:0]  IDX_ALARM_STATUS  = 8'h60;
	localparam logic [7:0]  IDX_CONV_STATUS   = 8'h61;
	localparam logic [7:0]  IDX_DATA_BASE     = 8'h70;
	localparam logic [15:0] RST_CH_LOWER      = 16'h0000;
	localparam logic [15:0] RST_CH_UPPER      = 16'h0000;
	localparam logic [15:0] RST_RANGE         = 16'hffff;
	localparam logic [15:0] RST_CLR_SOURCE    = 16'h0004;
	localparam logic [15:0] RST_CLR_EN        = 16'h0000;
	// writable field masks
	localparam logic [15:0] MASK_CH_LOWER     = 16'h7fff;
	localparam logic [15:0] MASK_CH_UPPER     = 16'h7000;
	localparam logic [15:0] MASK_RANGE        = 16'hffff;
	localparam logic [15:0] MASK_CLR_SOURCE   = 16'h7ffc;
	localparam logic [15:0] MASK_CLR_EN       = 16'h7ff8;
	// field positions
	localparam int          POS_OVERTEMP      = 2;
	localparam int          POS_ALARM_LSB     = 2;
	localparam int          POS_DAC_EN_LSB    = 3;
	localparam int          POS_UPPER_LSB     = 12;
	localparam int          POS_LOWER_MSB     = 14;
	localparam int          POS_DIFF01        = 12;
	localparam int          POS_DIFF23        = 9;
	// scan slots: 15 lower bits then 3 upper bits
	localparam int          NUM_SLOT          = 18;
	localparam logic [4:0]  LAST_SLOT         = 5'd17;
	localparam logic [15:0] CONV_TIME_NS      = 16'd2000;
	localparam logic [15:0] CLK_PERIOD_NS     = 16'd5;
	localparam logic [15:0] CONV_CYCLES       = 16'((CONV_TIME_NS + CLK_PERIOD_NS - 16'd1) / CLK_PERIOD_NS);
	typedef enum logic [2:0] {
		SCAN_IDLE = 3'b001,
		SCAN_REQ  = 3'b010,
		SCAN_WAIT = 3'b100
	} acr_scan_e;
endpackage
`default_nettype wire

/* logic/acr_scan.sv */
// conversion scanner: walks enabled slots in fixed order and stores results
`timescale 1ns/1ps
`default_nettype none
module acr_scan (
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	input  wire logic                  start_i,
	input  wire logic [17:0]           slot_en_i,
	input  wire logic [17:0]           slot_diff_i,
	input  wire logic [17:0]           slot_range_i,
	input  wire logic [11:0]           conv_data_i,
	output logic                       conv_start_o,
	output logic [3:0]                 conv_input_o,
	output logic                       conv_diff_o,
	output logic                       conv_range_o,
	output logic                       busy_o,
	output logic                       wr_o,
	output logic [3:0]                 wr_input_o,
	output logic [15:0]                wr_data_o
);
	import acr_pkg::*;
	acr_scan_e   state_reg;
	logic [4:0]  slot_reg;
	logic [15:0] wait_reg;
	logic [3:0]  in_of [NUM_SLOT];
	// lower bit 14..0 maps to inputs 0,1,pair0,2,3,pair2,4..12; upper to 13..15
	assign in_of = '{4'd0, 4'd1, 4'd0, 4'd2, 4'd3, 4'd2, 4'd4, 4'd5, 4'd6,
		4'd7, 4'd8, 4'd9, 4'd10, 4'd11, 4'd12, 4'd13, 4'd14, 4'd15};
	assign busy_o = (state_reg != SCAN_IDLE);
	always_ff @(posedge clock_i) begin
		conv_start_o <= 1'b0;
		wr_o <= 1'b0;
		if (reset_i) begin
			state_reg    <= SCAN_IDLE;
			slot_reg     <= '0;
			wait_reg     <= '0;
			conv_input_o <= '0;
			conv_diff_o  <= 1'b0;
			conv_range_o <= 1'b0;
			wr_input_o   <= '0;
			wr_data_o    <= '0;
		end else begin
			case (state_reg)
				SCAN_IDLE: begin
					slot_reg <= '0;
					if (start_i) begin
						state_reg <= SCAN_REQ;
					end
				end
				SCAN_REQ: begin
					// only slots whose bit is set are converted
					if (slot_en_i[slot_reg]) begin
						conv_start_o <= 1'b1;
						conv_input_o <= in_of[slot_reg];
						conv_diff_o  <= slot_diff_i[slot_reg];
						conv_range_o <= slot_range_i[slot_reg];
						wait_reg     <= CONV_CYCLES;
						state_reg    <= SCAN_WAIT;
					end else if (slot_reg == LAST_SLOT) begin
						state_reg <= SCAN_IDLE;
					end else begin
						slot_reg <= slot_reg + 5'd1;
					end
				end
				SCAN_WAIT: begin
					if (wait_reg <= 16'd1) begin
						wr_o       <= 1'b1;
						wr_input_o <= conv_input_o;
						// differential: sign-extended two's complement
						// single-ended: zero-extended straight binary
						wr_data_o  <= conv_diff_o ? {{4{conv_data_i[11]}}, conv_data_i}
							: {4'h0, conv_data_i};
						if (slot_reg == LAST_SLOT) begin
							state_reg <= SCAN_IDLE;
						end else begin
							slot_reg  <= slot_reg + 5'd1;
							state_reg <= SCAN_REQ;
						end
					end else begin
						wait_reg <= wait_reg - 16'd1;
					end
				end
				default: state_reg <= SCAN_IDLE;
			endcase
		end
	end
	AST_DIFF_SIGN: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_o && conv_diff_o |-> wr_data_o[15:12] == {4{wr_data_o[11]}})
		else $error("differential result not sign extended");
	AST_SE_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_o && !conv_diff_o |-> wr_data_o[15:12] == 4'h0)
		else $error("single-ended result not straight binary");
	AST_SKIP_OFF: assert property (@(posedge clock_i) disable iff (reset_i)
		state_reg == SCAN_REQ && !slot_en_i[slot_reg] |=> !conv_start_o)
		else $error("disabled slot converted");
endmodule
`default_nettype wire

/* logic/acr_regs.sv */
// register bank for scan select, input range and alarm-driven dac clear
`timescale 1ns/1ps
`default_nettype none
module acr_regs (
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [9:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	input  wire logic [12:0]           alarm_flags_i,
	input  wire logic                  dac_auto_mode_i,
	input  wire logic [11:0]           conv_data_i,
	output logic                       conv_start_o,
	output logic [3:0]                 conv_input_o,
	output logic                       conv_diff_o,
	output logic                       conv_range_o,
	output logic [11:0]                dac_clear_o
);
	import acr_pkg::*;
	logic [15:0] ch_lower_reg;
	logic [15:0] ch_upper_reg;
	logic [15:0] range_reg;
	logic [15:0] clr_source_reg;
	logic [15:0] clr_en_reg;
	logic [15:0] data_reg [NUM_IN];
	logic [12:0] flag_s1_reg;
	logic [12:0] flag_s2_reg;
	logic [11:0] dac_clear_reg;
	logic        mode_s1_reg;
	logic        mode_s2_reg;
	logic        req;
	logic        ack_reg;
	logic        err_reg;
	logic [7:0]  idx;
	logic        hit;
	logic        wr_en;
	logic [15:0] lane_mask;
	logic [15:0] rd_data;
	logic        busy;
	logic        scan_wr;
	logic [3:0]  scan_wr_input;
	logic [15:0] scan_wr_data;
	logic [17:0] slot_en;
	logic [17:0] slot_diff;
	logic [17:0] slot_range;
	logic        start_pending_reg;
	logic [12:0] source_en;
	logic [11:0] clear_next;

	assign idx       = wb_adr_i[9:2];
	assign req       = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign hit = (idx == IDX_CH_LOWER) || (idx == IDX_CH_UPPER) || (idx == IDX_RANGE)
		|| (idx == IDX_CLR_SOURCE) || (idx == IDX_CLR_EN) || (idx == IDX_ALARM_STATUS)
		|| (idx == IDX_CONV_STATUS) || (idx[7:4] == IDX_DATA_BASE[7:4]);
	assign wr_en     = req && hit && wb_we_i;
	assign wb_ack_o  = ack_reg;
	assign wb_err_o  = err_reg;

	// one-cycle answer: ack for mapped, err for unmapped
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			ack_reg <= req && hit;
			err_reg <= req && !hit;
		end
	end

	// writable fields only; reserved bits stay zero
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask);
		merge = ((old & ~lane_mask) | (wb_dat_i[15:0] & lane_mask)) & wmask;
	endfunction

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ch_lower_reg <= RST_CH_LOWER;
			ch_upper_reg <= RST_CH_UPPER;
			range_reg    <= RST_RANGE;
			clr_source_reg <= RST_CLR_SOURCE;
			clr_en_reg   <= RST_CLR_EN;
		end else if (wr_en) begin
			if (idx == IDX_CH_LOWER) begin
				ch_lower_reg <= merge(ch_lower_reg, MASK_CH_LOWER);
			end
			if (idx == IDX_CH_UPPER) begin
				ch_upper_reg <= merge(ch_upper_reg, MASK_CH_UPPER);
			end
			if (idx == IDX_RANGE) begin
				range_reg <= merge(range_reg, MASK_RANGE);
			end
			if (idx == IDX_CLR_SOURCE) begin
				clr_source_reg <= merge(clr_source_reg, MASK_CLR_SOURCE);
			end
			if (idx == IDX_CLR_EN) begin
				clr_en_reg <= merge(clr_en_reg, MASK_CLR_EN);
			end
		end
	end

	// a write to either select register launches one scan pass
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			start_pending_reg <= 1'b0;
		end else if (wr_en && (idx == IDX_CH_LOWER || idx == IDX_CH_UPPER)) begin
			start_pending_reg <= 1'b1;
		end else if (!busy) begin
			start_pending_reg <= 1'b0;
		end
	end

	// slot order: lower bits 14..0 then upper bits 14..12
	genvar g;
	generate
		for (g = 0; g < 15; g++) begin : g_lower
			assign slot_en[g] = ch_lower_reg[POS_LOWER_MSB - g];
		end
		for (g = 0; g < 3; g++) begin : g_upper
			assign slot_en[15 + g] = ch_upper_reg[POS_LOWER_MSB - g];
		end
	endgenerate
	assign slot_diff = 18'h00024;

	// range per slot: bit 15-n for input n, pairs follow inputs 0 and 2
	assign slot_range = {range_reg[0], range_reg[1], range_reg[2], range_reg[3],
		range_reg[4], range_reg[5], range_reg[6], range_reg[7], range_reg[8],
		range_reg[9], range_reg[10], range_reg[11], range_reg[13], range_reg[12],
		range_reg[13], range_reg[15], range_reg[14], range_reg[15]};

	acr_scan u_scan (
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.start_i      (start_pending_reg),
		.slot_en_i    (slot_en),
		.slot_diff_i  (slot_diff),
		.slot_range_i (slot_range),
		.conv_data_i  (conv_data_i),
		.conv_start_o (conv_start_o),
		.conv_input_o (conv_input_o),
		.conv_diff_o  (conv_diff_o),
		.conv_range_o (conv_range_o),
		.busy_o       (busy),
		.wr_o         (scan_wr),
		.wr_input_o   (scan_wr_input),
		.wr_data_o    (scan_wr_data)
	);

	// each result lands in its own input's data register
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			for (int i = 0; i < NUM_IN; i++) begin
				data_reg[i] <= '0;
			end
		end else if (scan_wr) begin
			data_reg[scan_wr_input] <= scan_wr_data;
		end
	end

	// alarm flags and dac mode come from other logic; synchronise
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			flag_s1_reg <= '0;
			flag_s2_reg <= '0;
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
		end else begin
			flag_s1_reg <= alarm_flags_i;
			flag_s2_reg <= flag_s1_reg;
			mode_s1_reg <= dac_auto_mode_i;
			mode_s2_reg <= mode_s1_reg;
		end
	end

	// clear ignores dac mode on purpose
	always_comb begin
		source_en  = clr_source_reg[POS_ALARM_LSB +: NUM_ALARM] & flag_s2_reg;
		clear_next = '0;
		// generic alarms need the per-dac enable
		if (|source_en[12:1]) begin
			clear_next = clr_en_reg[POS_DAC_EN_LSB +: NUM_DAC];
		end
		// overtemp clears every dac
		if (source_en[0]) begin
			clear_next = '1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			dac_clear_reg <= '0;
		end else begin
			dac_clear_reg <= clear_next;
		end
	end
	assign dac_clear_o = dac_clear_reg;

	always_comb begin
		rd_data = 16'h0000;
		case (idx)
			IDX_CH_LOWER:     rd_data = ch_lower_reg;
			IDX_CH_UPPER:     rd_data = ch_upper_reg;
			IDX_RANGE:        rd_data = range_reg;
			IDX_CLR_SOURCE:   rd_data = clr_source_reg;
			IDX_CLR_EN:       rd_data = clr_en_reg;
			IDX_ALARM_STATUS: rd_data = {1'b0, flag_s2_reg, 2'b00};
			IDX_CONV_STATUS:  rd_data = {14'h0000, mode_s2_reg, busy};
			default: begin
				if (idx[7:4] == IDX_DATA_BASE[7:4]) begin
					rd_data = data_reg[idx[3:0]];
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wb_dat_o <= '0;
		end else if (req && hit && !wb_we_i) begin
			wb_dat_o <= {16'h0000, rd_data};
		end
	end

	AST_UPPER_RESERVED: assert property (@(posedge clock_i) disable iff (reset_i)
		ch_upper_reg[15] == 1'b0 && ch_upper_reg[11:0] == 12'h000)
		else $error("upper select reserved bits set");
	AST_SOURCE_RESERVED: assert property (@(posedge clock_i) disable iff (reset_i)
		clr_source_reg[15] == 1'b0 && clr_source_reg[1:0] == 2'b00)
		else $error("alarm source reserved bits set");
	AST_RESET_VALUES: assert property (@(posedge clock_i)
		reset_i |=> ch_upper_reg == 16'h0000 && range_reg == 16'hffff
		&& clr_source_reg == 16'h0004)
		else $error("reset values wrong");
	AST_OVERTEMP_ALL: assert property (@(posedge clock_i) disable iff (reset_i)
		flag_s2_reg[0] && clr_source_reg[POS_OVERTEMP] |=> dac_clear_o == 12'hfff)
		else $error("overtemp did not clear all dacs");
	AST_OVERTEMP_OFF: assert property (@(posedge clock_i) disable iff (reset_i)
		!(|(clr_source_reg[14:3] & flag_s2_reg[12:1])) && !clr_source_reg[POS_OVERTEMP]
		|=> dac_clear_o == 12'h000)
		else $error("dac cleared with no enabled alarm");
	AST_GEN_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
		(|(clr_source_reg[14:3] & flag_s2_reg[12:1])) && !(flag_s2_reg[0]
		&& clr_source_reg[POS_OVERTEMP]) |=> dac_clear_o == $past(clr_en_reg[14:3]))
		else $error("generic alarm clear wrong");
	AST_ACK_ONE: assert property (@(posedge clock_i) disable iff (reset_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	// a taken request is answered on the very next edge
	sequence s_bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	AST_ANSWER_NEXT: assert property (@(posedge clock_i) disable iff (reset_i)
		s_bus_take |=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");
	AST_RANGE_PAIR: assert property (@(posedge clock_i) disable iff (reset_i)
		slot_range[2] == range_reg[15] && slot_range[5] == range_reg[13])
		else $error("pair range not from input bit");
	AST_RANGE_UPPER: assert property (@(posedge clock_i) disable iff (reset_i)
		slot_range[15] == range_reg[2] && slot_range[17] == range_reg[0])
		else $error("upper input range bit wrong");
	AST_ORDER_UPPER: assert property (@(posedge clock_i) disable iff (reset_i)
		slot_en[15] == ch_upper_reg[14] && slot_en[17] == ch_upper_reg[12])
		else $error("upper slot order wrong");
endmodule
`default_nettype wire

/* test/test_adc_sequence_gain_dac_clear_regs.sv */
// self-checking bench for the scan select, input range and dac-clear register block
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_gain_dac_clear_regs;
	import acr_pkg::*;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [9:0]  adr     = 10'h000;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] wdat    = 32'h0;
	logic [12:0] flags   = 13'h0000;
	logic        amode   = 1'b0;
	logic [11:0] cdata   = 12'h000;
	logic [31:0] rdat;
	logic        ack;
	logic        err;
	logic        cstart;
	logic        cdiff;
	logic        crange;
	logic [3:0]  cinput;
	logic [11:0] dclr;
	int          seed      = 32'h15ea09d4;
	int          bad_count = 0;
	int          checks    = 0;
	logic [5:0]  q_ev[$];
	logic [11:0] q_val[$];
	logic [15:0] rd;
	logic [15:0] rng;
	logic [15:0] src;
	logic [15:0] en;
	logic [15:0] fl;
	logic        er;

	acr_regs dut_u (.clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .alarm_flags_i(flags), .dac_auto_mode_i(amode),
		.conv_data_i(cdata), .conv_start_o(cstart), .conv_input_o(cinput),
		.conv_diff_o(cdiff), .conv_range_o(crange), .dac_clear_o(dclr));

	always #2.5 clock_i = ~clock_i;

	// converter stand-in: logs each conversion and supplies a fresh result
	always @(posedge clock_i) begin
		logic [11:0] v;
		if (!reset_i && cstart === 1'b1) begin
			v = 12'($random(seed));
			if (cdiff) v[11] = 1'b1;
			q_ev.push_back({cdiff, crange, cinput});
			q_val.push_back(v);
			cdata <= v;
		end
	end

	task automatic results();
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic miss(input logic [15:0] got, input logic [15:0] exp);
		bad_count++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
	endtask

	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) miss(got, exp);
	endtask

	task automatic cmp_clr(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) miss({4'h0, got}, {4'h0, exp});
	endtask

	task automatic cmp_ev(input logic [5:0] got, input logic [5:0] exp);
		checks++;
		if (got !== exp) miss({10'h0, got}, {10'h0, exp});
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) miss({15'h0, got}, {15'h0, exp});
	endtask

	task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd,
		output logic [15:0] r, output logic e);
		int n;
		@(posedge clock_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		sel  <= 4'h3;
		wdat <= {16'h0, wd};
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
		if (ack !== 1'b1 && err !== 1'b1) begin
			bad_count++;
			results();
		end
		r = rdat[15:0];
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask

	function automatic logic [5:0] slot_ev(input int b, input logic up);
		logic [3:0] n;
		n = up ? 4'(27 - b) : b >= 13 ? 4'(14 - b) : b == 12 ? 4'd0 :
			b >= 10 ? 4'(13 - b) : b == 9 ? 4'd2 : 4'(12 - b);
		return {!up && (b == 12 || b == 9), rng[15 - n], n};
	endfunction

	function automatic logic [11:0] exp_clear(input logic [15:0] s, input logic [15:0] e,
		input logic [12:0] f);
		exp_clear = 12'h000;
		if (|(s[14:3] & f[12:1])) exp_clear = e[14:3];
		if (s[2] & f[0]) exp_clear = 12'hfff;
	endfunction

	// one register write that starts a pass; low/up are the select values then in force
	task automatic run_scan(input logic [7:0] idx, input logic [15:0] wv,
		input logic [15:0] low, input logic [15:0] up);
		logic [5:0]  exp_q[$];
		logic [11:0] v;
		int          k;
		for (int b = 14; b >= 0; b--) if (low[b]) exp_q.push_back(slot_ev(b, 1'b0));
		for (int b = 14; b >= 12; b--) if (up[b]) exp_q.push_back(slot_ev(b, 1'b1));
		q_ev.delete();
		q_val.delete();
		bus(1'b1, idx, wv, rd, er);
		k = 0;
		while (q_ev.size() < exp_q.size() && k < 5000) begin
			@(posedge clock_i);
			k++;
		end
		repeat (4) @(posedge clock_i);
		do begin
			bus(1'b0, IDX_CONV_STATUS, 16'h0, rd, er);
			k++;
		end while (rd[0] !== 1'b0 && k < 5000);
		if (k >= 5000) begin
			bad_count++;
			results();
		end
		cmp_reg(16'(q_ev.size()), 16'(exp_q.size()));
		for (int i = 0; i < q_ev.size() && i < exp_q.size(); i++) begin
			cmp_ev(q_ev[i], exp_q[i]);
			v = q_val[i];
			bus(1'b0, IDX_DATA_BASE + 8'(q_ev[i][3:0]), 16'h0, rd, er);
			cmp_reg(rd, q_ev[i][5] ? {{4{v[11]}}, v} : {4'h0, v});
		end
	endtask

	initial begin
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		bus(1'b0, IDX_CH_UPPER, 16'h0, rd, er);
		cmp_reg(rd, 16'h0000);
		bus(1'b0, IDX_RANGE, 16'h0, rd, er);
		cmp_reg(rd, 16'hffff);
		cmp_flag(er, 1'b0);
		bus(1'b0, IDX_CLR_SOURCE, 16'h0, rd, er);
		cmp_reg(rd, 16'h0004);
		cmp_clr(dclr, 12'h000);
		// unmapped index is refused and leaves the map untouched
		bus(1'b1, 8'h40, 16'hffff, rd, er);
		cmp_flag(er, 1'b1);
		bus(1'b0, 8'h40, 16'h0, rd, er);
		cmp_flag(er, 1'b1);
		for (int i = 0; i < 8; i++) begin
			rng = i == 0 ? 16'h0000 : 16'($random(seed));
			bus(1'b1, IDX_RANGE, rng, rd, er);
			bus(1'b0, IDX_RANGE, 16'h0, rd, er);
			cmp_reg(rd, rng);
		end
		// reserved bit 15 set on purpose; inputs 13 and 15 only
		run_scan(IDX_CH_UPPER, 16'hd000, 16'h0000, 16'h5000);
		bus(1'b0, IDX_CH_UPPER, 16'h0, rd, er);
		cmp_reg(rd, 16'h5000);
		run_scan(IDX_CH_UPPER, 16'h0000, 16'h0000, 16'h0000);
		run_scan(IDX_CH_LOWER, 16'h9201, 16'h1201, 16'h0000);
		run_scan(IDX_CH_UPPER, 16'h7000, 16'h1201, 16'h7000);
		for (int i = 0; i < 24; i++) begin
			case (i)
				0: {src, en, fl} = {16'h0004, 16'h0000, 16'h0001};
				1: {src, en, fl} = {16'h0000, 16'h7ff8, 16'h1fff};
				2: {src, en, fl} = {16'h4000, 16'h0048, 16'h1000};
				3: {src, en, fl} = {16'hfffb, 16'hffff, 16'h0001};
				default: begin
					src = 16'($random(seed));
					en  = 16'($random(seed));
					fl  = 16'($random(seed) & $random(seed) & $random(seed));
				end
			endcase
			bus(1'b1, IDX_CLR_SOURCE, src, rd, er);
			bus(1'b1, IDX_CLR_EN, en, rd, er);
			bus(1'b0, IDX_CLR_SOURCE, 16'h0, rd, er);
			cmp_reg(rd, src & 16'h7ffc);
			flags <= fl[12:0];
			amode <= i[0];
			repeat (6) @(posedge clock_i);
			cmp_clr(dclr, exp_clear(src & 16'h7ffc, en & 16'h7ff8, fl[12:0]));
		end
		results();
	end
endmodule
`default_nettype wire
